/* File: design/csr_top.sv */
`timescale 1ns/1ps
`include "csr_defines.svh"

// Behaviour
// - Trigger level rebuilt by a toggle flop flipped on each trigger edge.
// - Exposure from twelve fixed steps or a programmed line count.
// - Pulse-width trigger modes expose for the trigger's low time.
// - Delayed readout works with edge or pulse-width exposure.
// - Continuous, four trigger modes, long exposure; all lock to external sync.
// - High frame rate keeps one line in three, dropping the two between.
// - High frame rate shifts vertically three times faster, frame a third long.
// - Without external line sync the internal line timer runs alone.
// - Without external frame sync the internal frame timer runs alone.
// - Sync pins set as outputs carry the internal line and frame sync.
// - Composite sync on green by serial command or internal switch.
// - Serial port sets everything; local switches set most things.
// - Triggered exposure starts at the first line pulse after trigger fall.
// - Write-valid strobe marks valid video after an exposure.
module csr_top #(
  parameter int LINE_CYCLES = `CSR_LINE_CYCLES,
  parameter int FRAME_LINES = `CSR_FRAME_LINES,
  parameter int READ_LINES  = `CSR_READ_LINES,
  parameter int FIFO_DEPTH  = `CSR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Configuration
  input  wire logic                remote_en,
  input  wire csr_pkg::csr_cfg_t   cfg_remote,
  input  wire csr_pkg::csr_cfg_t   cfg_switch,
  // Trigger pin
  input  wire logic                trigger_in,
  // Line sync pin
  input  wire logic                line_sync_i,
  output logic                     line_sync_o,
  output logic                     line_sync_oe,
  // Frame sync pin
  input  wire logic                frame_sync_i,
  output logic                     frame_sync_o,
  output logic                     frame_sync_oe,
  // Strobes and status
  output logic                     exposure_active_out,
  output logic                     write_valid_out,
  output logic                     green_sync_out,
  output logic                     sync_pin_out,
  output logic                     vshift_pulse,
  output logic                     line_locked,
  output logic                     frame_locked,
  // Line stream
  output logic                     line_valid,
  input  wire logic                line_ready,
  output csr_pkg::csr_line_t       line_data
);

  localparam int LW = 16;
  localparam int FW = 12;
  localparam logic [LW-1:0] LINE_LAST = LW'(LINE_CYCLES - 1);
  localparam logic [LW-1:0] LINE_LOSS = LW'(`CSR_LOSS_PERIODS * LINE_CYCLES - 1);
  localparam logic [LW-1:0] VT_LAST   = LW'(LINE_CYCLES / `CSR_HFR_DIV - 1);
  localparam logic [LW-1:0] PULSE_LEN = LW'(`CSR_SYNC_PULSE_CYCLES);
  localparam logic [FW-1:0] FRM_FULL  = FW'(FRAME_LINES);
  localparam logic [FW-1:0] FRM_HFR   = FW'(FRAME_LINES / `CSR_HFR_DIV);
  localparam logic [FW-1:0] FRM_LOSS  = FW'(`CSR_LOSS_PERIODS * FRAME_LINES - 1);
  localparam logic [9:0]    ROW_LAST  = 10'(READ_LINES - 1);
  localparam logic [9:0]    PROG_MIN  = 10'(`CSR_PROG_MIN);
  localparam logic [9:0]    PROG_MAX  = 10'(`CSR_PROG_MAX);
  localparam logic [3:0]    STEP_LAST = 4'(`CSR_STEP_COUNT - 1);
  csr_pkg::csr_cfg_t   cfg;
  csr_pkg::csr_state_t state_q;
  logic [2:0]          pin_meta_q;
  logic [2:0]          pin_sync_q;
  logic [2:0]          pin_prev_q;
  logic [2:0]          pin_rise;
  logic [2:0]          pin_fall;
  logic                trig_low_q;
  logic                trig_toggle;
  logic                trig_start;
  logic [LW-1:0]       line_cnt_q;
  logic                line_lock_q;
  logic                ext_line_edge;
  logic                line_tick;
  logic [LW-1:0]       vt_cnt_q;
  logic                vtick;
  logic [FW-1:0]       frame_line_q;
  logic [FW-1:0]       frame_len;
  logic                frame_lock_q;
  logic                ext_frame_edge;
  logic                frame_tick;
  logic [FW-1:0]       exp_cnt_q;
  logic [FW-1:0]       exp_lines;
  logic                exp_done;
  logic                pw_mode;
  logic                delay_mode;
  logic [9:0]          row_q;
  logic [1:0]          phase_q;
  logic                keep_row;
  logic                fifo_in_ready;
  logic                shift_go;
  logic                csync;

  // Local switches cannot reach programmed exposure or high frame rate
  always_comb begin
    cfg = cfg_remote;
    if (!remote_en) begin
      cfg                 = cfg_switch;
      cfg.prog_shutter    = 1'h0;
      cfg.prog_lines      = '0;
      cfg.high_frame_rate = 1'h0;
    end
  end

  // Pins: bit 0 line sync, bit 1 frame sync, bit 2 trigger
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (reset) begin
          pin_meta_q[i] <= `CSR_RESET_PIN;
          pin_sync_q[i] <= `CSR_RESET_PIN;
          pin_prev_q[i] <= `CSR_RESET_PIN;
        end else begin
          pin_meta_q[i] <= (i == 0) ? line_sync_i : (i == 1) ? frame_sync_i : trigger_in;
          pin_sync_q[i] <= pin_meta_q[i];
          pin_prev_q[i] <= pin_sync_q[i];
        end
      end
    end
  endgenerate

  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign pin_fall = ~pin_sync_q & pin_prev_q;
  // Either edge flips the level; a missed edge would leave it inverted from then on
  assign trig_toggle = pin_rise[2] | pin_fall[2];
  assign trig_start  = trig_toggle & ~trig_low_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_low_q <= `CSR_RESET_TRIG_LOW;
    end else if (trig_toggle) begin
      trig_low_q <= ~trig_low_q;
    end
  end

  // Line timer: external edges restart it; after loss it free-runs
  assign ext_line_edge = pin_rise[0] & ~cfg.sync_out;
  assign line_tick     = ext_line_edge | (!line_lock_q && line_cnt_q >= LINE_LAST);

  always_ff @(posedge clk) begin
    if (reset) begin
      line_cnt_q  <= '0;
      line_lock_q <= `CSR_RESET_LOCK;
    end else begin
      line_cnt_q <= line_tick ? '0 : line_cnt_q + 1'h1;
      if (ext_line_edge) begin
        line_lock_q <= 1'h1;
      end else if (line_cnt_q == LINE_LOSS || cfg.sync_out) begin
        line_lock_q <= 1'h0;
      end
    end
  end

  // Vertical clock: three shifts per line in high frame rate
  assign vtick = cfg.high_frame_rate ? (line_tick | vt_cnt_q == VT_LAST) : line_tick;

  always_ff @(posedge clk) begin
    if (reset) begin
      vt_cnt_q <= '0;
    end else begin
      vt_cnt_q <= vtick ? '0 : vt_cnt_q + 1'h1;
    end
  end

  // Frame timer counts lines; frame is a third long in high frame rate
  assign frame_len      = cfg.high_frame_rate ? FRM_HFR : FRM_FULL;
  assign ext_frame_edge = pin_rise[1] & ~cfg.sync_out;
  assign frame_tick     = ext_frame_edge |
                          (line_tick && !frame_lock_q && frame_line_q >= frame_len - 1'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_line_q <= '0;
      frame_lock_q <= `CSR_RESET_LOCK;
    end else begin
      if (frame_tick) begin
        frame_line_q <= '0;
      end else if (line_tick) begin
        frame_line_q <= frame_line_q + 1'h1;
      end
      if (ext_frame_edge) begin
        frame_lock_q <= 1'h1;
      end else if ((line_tick && frame_line_q == FRM_LOSS) || cfg.sync_out) begin
        frame_lock_q <= 1'h0;
      end
    end
  end

  // Exposure length in lines
  always_comb begin
    if (cfg.prog_shutter) begin
      if (cfg.prog_lines < PROG_MIN) begin
        exp_lines = FW'(PROG_MIN);
      end else if (cfg.prog_lines > PROG_MAX) begin
        exp_lines = FW'(PROG_MAX);
      end else begin
        exp_lines = FW'(cfg.prog_lines);
      end
    end else begin
      exp_lines = frame_len >> ((cfg.shutter_step > STEP_LAST) ? STEP_LAST : cfg.shutter_step);
      if (exp_lines == '0) begin
        exp_lines = FW'(1);
      end
    end
  end

  assign pw_mode    = (cfg.mode == csr_pkg::CSR_MODE_PULSE_WIDTH) ||
                      (cfg.mode == csr_pkg::CSR_MODE_DELAY_PULSE);
  assign delay_mode = (cfg.mode == csr_pkg::CSR_MODE_DELAY_EDGE) ||
                      (cfg.mode == csr_pkg::CSR_MODE_DELAY_PULSE);

  // End of exposure for the selected mode
  always_comb begin
    if (cfg.mode == csr_pkg::CSR_MODE_LONG_EXPOSURE) begin
      exp_done = frame_tick;
    end else if (pw_mode) begin
      exp_done = line_tick && !trig_low_q;
    end else begin
      exp_done = line_tick && (exp_cnt_q >= exp_lines - 1'h1);
    end
  end

  // Sequencer; sync locking above serves every mode alike
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= csr_pkg::CSR_ST_IDLE;
    end else begin
      case (state_q)
        csr_pkg::CSR_ST_IDLE: begin
          if (cfg.mode == csr_pkg::CSR_MODE_CONTINUOUS ||
              cfg.mode == csr_pkg::CSR_MODE_LONG_EXPOSURE) begin
            if (frame_tick) begin
              state_q <= csr_pkg::CSR_ST_EXPOSE;
            end
          end else if (trig_start) begin
            state_q <= csr_pkg::CSR_ST_ARMED;
          end
        end
        csr_pkg::CSR_ST_ARMED: begin
          if (line_tick) begin
            state_q <= csr_pkg::CSR_ST_EXPOSE;
          end
        end
        csr_pkg::CSR_ST_EXPOSE: begin
          if (exp_done) begin
            state_q <= delay_mode ? csr_pkg::CSR_ST_HOLD : csr_pkg::CSR_ST_READ;
          end
        end
        csr_pkg::CSR_ST_HOLD: begin
          if (frame_tick) begin
            state_q <= csr_pkg::CSR_ST_READ;
          end
        end
        csr_pkg::CSR_ST_READ: begin
          if (shift_go && row_q == ROW_LAST) begin
            state_q <= csr_pkg::CSR_ST_IDLE;
          end
        end
        default: begin
          state_q <= csr_pkg::CSR_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_q != csr_pkg::CSR_ST_EXPOSE) begin
      exp_cnt_q <= '0;
    end else if (line_tick) begin
      exp_cnt_q <= exp_cnt_q + 1'h1;
    end
  end

  // Readout: a full buffer stalls the vertical shift rather than lose a row
  assign keep_row = !cfg.high_frame_rate || phase_q == 2'h0;
  assign shift_go = (state_q == csr_pkg::CSR_ST_READ) && vtick && (fifo_in_ready || !keep_row);

  always_ff @(posedge clk) begin
    if (reset || state_q != csr_pkg::CSR_ST_READ) begin
      row_q   <= '0;
      phase_q <= '0;
    end else if (shift_go) begin
      row_q   <= row_q + 1'h1;
      phase_q <= (phase_q == 2'(`CSR_HFR_DIV - 1)) ? '0 : phase_q + 1'h1;
    end
  end
  csr_fifo #(
    .WIDTH ($bits(csr_pkg::csr_line_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_csr_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (shift_go && keep_row),
    .in_ready  (fifo_in_ready),
    .in_data   ({row_q, cfg.high_frame_rate}),
    .out_valid (line_valid),
    .out_ready (line_ready),
    .out_data  (line_data)
  );

  // Strobes decoded from the state register
  assign exposure_active_out = (state_q == csr_pkg::CSR_ST_EXPOSE);
  assign write_valid_out     = (state_q == csr_pkg::CSR_ST_READ);

  assign csync = (line_cnt_q < PULSE_LEN) || (frame_line_q == '0);
  always_ff @(posedge clk) begin
    if (reset) begin
      line_sync_o    <= 1'h0;
      line_sync_oe   <= 1'h0;
      frame_sync_o   <= 1'h0;
      frame_sync_oe  <= 1'h0;
      green_sync_out <= 1'h0;
      sync_pin_out   <= 1'h0;
      vshift_pulse   <= 1'h0;
    end else begin
      line_sync_o    <= line_cnt_q < PULSE_LEN;
      line_sync_oe   <= cfg.sync_out;
      frame_sync_o   <= frame_line_q == '0;
      frame_sync_oe  <= cfg.sync_out;
      green_sync_out <= cfg.sync_on_green_cmd & csync;
      sync_pin_out   <= cfg.sync_pin_select_cmd ? write_valid_out : csync;
      vshift_pulse   <= shift_go;
    end
  end
  assign line_locked  = line_lock_q;
  assign frame_locked = frame_lock_q;

endmodule

/* File: shared/csr_defines.svh */
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// Clock and line timing
`define CSR_CLK_PERIOD_NS 10
`define CSR_LINE_PERIOD_NS 51000
`define CSR_LINE_CYCLES (`CSR_LINE_PERIOD_NS / `CSR_CLK_PERIOD_NS)
`define CSR_SYNC_PULSE_NS 4000
`define CSR_SYNC_PULSE_CYCLES (`CSR_SYNC_PULSE_NS / `CSR_CLK_PERIOD_NS)

// Frame format in lines
`define CSR_FRAME_LINES 784
`define CSR_READ_LINES 770
`define CSR_HFR_DIV 3
`define CSR_LOSS_PERIODS 2

// Shutter
`define CSR_STEP_COUNT 12
`define CSR_PROG_MIN 3
`define CSR_PROG_MAX 790

// Line stream buffer
`define CSR_FIFO_DEPTH 4

// Reset values
`define CSR_RESET_TRIG_LOW 1'h0
`define CSR_RESET_LOCK 1'h0
`define CSR_RESET_PIN 1'h1

`endif

/* File: shared/csr_pkg.sv */
package csr_pkg;

  typedef enum logic [2:0] {
    CSR_MODE_CONTINUOUS,
    CSR_MODE_EDGE_PRESELECT,
    CSR_MODE_PULSE_WIDTH,
    CSR_MODE_DELAY_EDGE,
    CSR_MODE_DELAY_PULSE,
    CSR_MODE_LONG_EXPOSURE
  } csr_mode_t;

  typedef enum logic [2:0] {
    CSR_ST_IDLE,
    CSR_ST_ARMED,
    CSR_ST_EXPOSE,
    CSR_ST_HOLD,
    CSR_ST_READ
  } csr_state_t;

  typedef struct packed {
    csr_mode_t  mode;
    logic       prog_shutter;
    logic [3:0] shutter_step;
    logic [9:0] prog_lines;
    logic       high_frame_rate;
    logic       sync_out;
    logic       sync_on_green_cmd;
    logic       sync_pin_select_cmd;
  } csr_cfg_t;

  typedef struct packed {
    logic [9:0] sensor_row;
    logic       high_frame_rate;
  } csr_line_t;

endpackage

/* File: design/csr_fifo.sv */
`timescale 1ns/1ps

module csr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // DEPTH must be at least 2
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'h1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'h1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'h1;
    end
  end

endmodule

/* File: verif/csr_top_props.sv */
`timescale 1ns/1ps
module csr_top_props #(
  parameter int LINE_CYCLES = 5100,
  parameter int FRAME_LINES = 784,
  parameter int READ_LINES  = 770,
  parameter int FIFO_DEPTH  = 4
) (
  // Clock, reset, configuration
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               remote_en,
  input wire csr_pkg::csr_cfg_t  cfg_remote,
  input wire csr_pkg::csr_cfg_t  cfg_switch,
  // Pins and strobes
  input wire logic               line_sync_o,
  input wire logic               line_sync_oe,
  input wire logic               frame_sync_oe,
  input wire logic               exposure_active_out,
  input wire logic               write_valid_out,
  input wire logic               green_sync_out,
  input wire logic               sync_pin_out,
  input wire logic               line_locked,
  input wire logic               frame_locked,
  // Line stream
  input wire logic               line_valid,
  input wire logic               line_ready,
  input wire csr_pkg::csr_line_t line_data
);
  // Sync pulse width is fixed in time, not scaled with the line length
  localparam int PW1 = 399;
  csr_pkg::csr_cfg_t cfg;
  assign cfg = remote_en ? cfg_remote : cfg_switch;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_oe_copy;
    1'h1 |=> line_sync_oe == $past(cfg.sync_out);
  endproperty
  a_oe_copy: assert property (p_oe_copy) else $error("pin direction wrong");
  property p_oe_pair;
    line_sync_oe == frame_sync_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("sync pin directions differ");
  property p_lock_off;
    line_sync_oe |-> !line_locked && !frame_locked;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("locked while driving sync");
  property p_green;
    $rose(green_sync_out) |-> $past(cfg.sync_on_green_cmd);
  endproperty
  a_green: assert property (p_green) else $error("green sync without command");
  property p_pin_sel;
    $past(cfg.sync_pin_select_cmd) |-> sync_pin_out == $past(write_valid_out);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("sync pin not write valid");
  property p_excl;
    !(exposure_active_out && write_valid_out);
  endproperty
  a_excl: assert property (p_excl) else $error("exposure and readout overlap");
  property p_wv_after;
    $fell(exposure_active_out) &&
      !(cfg.mode inside {csr_pkg::CSR_MODE_DELAY_EDGE, csr_pkg::CSR_MODE_DELAY_PULSE})
      |-> write_valid_out;
  endproperty
  a_wv_after: assert property (p_wv_after) else $error("no write valid after exposure");
  property p_hold;
    line_valid && !line_ready |=> line_valid && $stable(line_data);
  endproperty
  a_hold: assert property (p_hold) else $error("line word changed while stalled");
  property p_hfr_rows;
    line_valid && line_data.high_frame_rate |-> line_data.sensor_row % 3 == 0;
  endproperty
  a_hfr_rows: assert property (p_hfr_rows) else $error("dropped row delivered");
  property p_pulse;
    $rose(line_sync_o) && line_sync_oe |-> ##[PW1:PW1] line_sync_o ##1 !line_sync_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("line sync pulse width wrong");
endmodule

bind csr_top csr_top_props #(
  .LINE_CYCLES(LINE_CYCLES),
  .FRAME_LINES(FRAME_LINES),
  .READ_LINES(READ_LINES),
  .FIFO_DEPTH(FIFO_DEPTH)
) u_csr_top_props (
  .clk, .reset, .remote_en, .cfg_remote, .cfg_switch, .line_sync_o, .line_sync_oe,
  .frame_sync_oe, .exposure_active_out, .write_valid_out, .green_sync_out, .sync_pin_out,
  .line_locked, .frame_locked, .line_valid, .line_ready, .line_data
);

/* File: verif/csr_sync_source.sv */
`timescale 1ns/1ps
module csr_sync_source #(
  parameter int LINE_CYCLES = 420,
  parameter int FRAME_LINES = 12
) (
  // Clock and controls
  input  wire logic clk,
  input  wire logic ext_en,
  input  wire logic stall,
  // Pins toward the camera
  output logic      line_pin,
  output logic      frame_pin,
  output logic      trig_pin_n,
  // Line stream side
  output logic      ready
);
  int cyc = 0;
  int ln  = 0;
  initial trig_pin_n = 1'h1;
  always @(negedge clk) begin
    cyc <= (cyc == LINE_CYCLES - 1) ? 0 : cyc + 1;
    if (cyc == LINE_CYCLES - 1) begin
      ln <= (ln == FRAME_LINES - 1) ? 0 : ln + 1;
    end
  end
  // Released pins read high through the pull-up; frame rise coincides with a line rise
  assign line_pin  = !ext_en || cyc >= 40;
  assign frame_pin = !ext_en || ln != 0 || cyc >= 40;
  // Slow consumer: one word in four cycles at best
  assign ready = !stall && cyc[1:0] == 2'h0;
  task automatic fire(input int low_lines);
    @(negedge clk);
    trig_pin_n = 1'h0;
    repeat (low_lines * LINE_CYCLES) @(negedge clk);
    trig_pin_n = 1'h1;
  endtask
endmodule

/* File: verif/tb_csr_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_csr_top;
  localparam int LC = 420;
  localparam int FL = 12;
  localparam int RL = 9;
  logic clk, reset, remote_en, trigger_in, line_sync_i, line_sync_o, line_sync_oe;
  logic frame_sync_i, frame_sync_o, frame_sync_oe, exposure_active_out, write_valid_out;
  logic green_sync_out, sync_pin_out, vshift_pulse, line_locked, frame_locked;
  logic line_valid, line_ready, pl, pf, ext_en, stall;
  csr_pkg::csr_cfg_t  cfg_remote, cfg_switch;
  csr_pkg::csr_line_t line_data;
  csr_pkg::csr_line_t got[$];
  int errors, checked, cycles, exp_cnt, wv_cnt, vs_cnt;
  assign line_sync_i  = line_sync_oe ? line_sync_o : pl;
  assign frame_sync_i = frame_sync_oe ? frame_sync_o : pf;
  csr_top #(.LINE_CYCLES(LC), .FRAME_LINES(FL), .READ_LINES(RL), .FIFO_DEPTH(4)) u_csr_top (
    .clk, .reset, .remote_en, .cfg_remote, .cfg_switch, .trigger_in, .line_sync_i,
    .line_sync_o, .line_sync_oe, .frame_sync_i, .frame_sync_o, .frame_sync_oe,
    .exposure_active_out, .write_valid_out, .green_sync_out, .sync_pin_out, .vshift_pulse,
    .line_locked, .frame_locked, .line_valid, .line_ready, .line_data);
  csr_sync_source #(.LINE_CYCLES(LC), .FRAME_LINES(FL)) u_csr_sync_source (
    .clk, .ext_en, .stall, .line_pin(pl), .frame_pin(pf), .trig_pin_n(trigger_in),
    .ready(line_ready));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (line_valid && line_ready) got.push_back(line_data);
    if (exposure_active_out) exp_cnt++;
    if (write_valid_out) wv_cnt++;
    if (vshift_pulse) vs_cnt++;
    if (cycles == 120000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cycles from one rising edge of the chosen sync output to the next
  task automatic period(input logic f, output int n);
    int k;
    k = 0;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while ((f ? frame_sync_o : line_sync_o) === 1'h1 && k < 30000) begin
        @(negedge clk);
        k++;
        n++;
      end
      while ((f ? frame_sync_o : line_sync_o) !== 1'h1 && k < 30000) begin
        @(negedge clk);
        k++;
        n++;
      end
    end
  endtask
  task automatic sync_tests;
    int n;
    remote_en = 1'h0;
    cfg_switch.sync_out = 1'h1;
    repeat (2) @(negedge clk);
    `CHK(line_sync_oe, 1'h1)
    remote_en = 1'h1;
    cfg_remote.sync_out = 1'h1;
    cfg_remote.sync_on_green_cmd = 1'h1;
    repeat (2) @(negedge clk);
    `CHK(frame_sync_oe, 1'h1)
    period(1'h0, n);
    `CHK(n, LC)
    period(1'h1, n);
    `CHK(n, FL * LC)
    cfg_remote.sync_pin_select_cmd = 1'h0;
    repeat (2) @(negedge clk);
    `CHK(green_sync_out, 1'h1)
    `CHK(sync_pin_out, 1'h1)
    cfg_remote.sync_on_green_cmd = 1'h0;
    cfg_remote.sync_pin_select_cmd = 1'h1;
    repeat (2) @(negedge clk);
    `CHK(green_sync_out, 1'h0)
    `CHK(sync_pin_out, 1'h0)
    cfg_remote.sync_out = 1'h0;
    cfg_switch.sync_out = 1'h0;
    repeat (LC) @(negedge clk);
    ext_en = 1'h1;
    repeat ((FL + 2) * LC) @(negedge clk);
    `CHK({line_locked, frame_locked}, 2'h3)
    ext_en = 1'h0;
    repeat (3 * LC) @(negedge clk);
    `CHK(line_locked, 1'h0)
    period(1'h0, n);
    `CHK(n, LC)
    period(1'h1, n);
    `CHK(n, FL * LC)
    $display("test sync done");
  endtask
  task automatic capture(input csr_pkg::csr_mode_t m, input logic h, input int lo,
                         input int hi, input logic st);
    csr_pkg::csr_line_t e[$];
    int k;
    @(negedge clk);
    cfg_remote.mode = m;
    cfg_remote.high_frame_rate = h;
    stall = st;
    got.delete();
    exp_cnt = 0;
    wv_cnt = 0;
    vs_cnt = 0;
    k = 0;
    for (int i = 0; i < RL; i++) if (!h || i % 3 == 0) e.push_back({i[9:0], h});
    if (m != csr_pkg::CSR_MODE_CONTINUOUS) begin
      u_csr_sync_source.fire(m inside {csr_pkg::CSR_MODE_PULSE_WIDTH,
                                       csr_pkg::CSR_MODE_DELAY_PULSE} ? 5 : 3);
    end
    while (write_valid_out !== 1'h1 && k < 30000) begin
      @(negedge clk);
      k++;
    end
    // Long stall fills the buffer so row shifts must wait for room
    if (st) repeat (7 * LC) @(negedge clk);
    stall = 1'h0;
    while ((write_valid_out !== 1'h0 || got.size() < e.size()) && k < 60000) begin
      @(negedge clk);
      k++;
    end
    `CHK(got.size(), e.size())
    foreach (e[i]) `CHK(got[i], e[i])
    `CHK(exp_cnt >= lo && exp_cnt <= hi, 1'h1)
    `CHK(h ? wv_cnt <= RL * LC / 2 : wv_cnt >= (RL - 1) * LC, 1'h1)
    if (!h) `CHK(vs_cnt, RL)
    $display("test %s done", m.name());
  endtask
  initial begin
    reset = 1'h1;
    remote_en = 1'h1;
    ext_en = 1'h0;
    stall = 1'h0;
    cfg_switch = '0;
    cfg_remote = '0;
    cfg_remote.mode = csr_pkg::CSR_MODE_EDGE_PRESELECT;
    cfg_remote.prog_shutter = 1'h1;
    cfg_remote.prog_lines = 10'h003;
    cfg_remote.sync_pin_select_cmd = 1'h1;
    cfg_switch.mode = csr_pkg::CSR_MODE_EDGE_PRESELECT;
    repeat (16) @(negedge clk);
    reset = 1'h0;
    repeat (2) @(negedge clk);
    `CHK({exposure_active_out, write_valid_out, line_valid}, 3'h0)
    sync_tests();
    capture(csr_pkg::CSR_MODE_CONTINUOUS, 1'h0, 3 * LC, 3 * LC, 1'h0);
    capture(csr_pkg::CSR_MODE_EDGE_PRESELECT, 1'h0, 3 * LC, 3 * LC, 1'h1);
    capture(csr_pkg::CSR_MODE_PULSE_WIDTH, 1'h0, 4 * LC, 6 * LC, 1'h0);
    capture(csr_pkg::CSR_MODE_DELAY_EDGE, 1'h0, 3 * LC, 3 * LC, 1'h0);
    capture(csr_pkg::CSR_MODE_DELAY_PULSE, 1'h0, 4 * LC, 6 * LC, 1'h0);
    capture(csr_pkg::CSR_MODE_EDGE_PRESELECT, 1'h1, 3 * LC, 3 * LC, 1'h0);
    capture(csr_pkg::CSR_MODE_LONG_EXPOSURE, 1'h0, FL * LC, FL * LC, 1'h0);
    report_and_stop();
  end
endmodule
